// file: hw/seq_pkg.sv
// Shared constants for the supply sequencing state engine.
package seq_pkg;
	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int NUM_IN = 10;
	localparam int NUM_OUT = 10;
	localparam int NUM_CELLS = 63;
	localparam int WORDS_PER_CELL = 4;
	localparam int TABLE_WORDS = NUM_CELLS * WORDS_PER_CELL;
	localparam int PUMP_OUTPUTS = 6;
	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_NS = 10000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int CLKOUT_HZ = 100000;
	localparam int CLKOUT_HALF_NS = 1000000000 / CLKOUT_HZ / 2;
	localparam int CLKOUT_HALF_CYCLES = CLKOUT_HALF_NS / CLK_PERIOD_NS;
	localparam int DELAY_MAX_MS = 400;
	localparam int DELAY_MAX_TICKS = DELAY_MAX_MS * 1000000 / TICK_NS;
	localparam int TRANSITION_MAX_NS = 20000;
	localparam int TRANSITION_MAX_CYCLES = TRANSITION_MAX_NS / CLK_PERIOD_NS;
	localparam int EX_TIMEOUT1_MS = 10;
	localparam int EX_TIMEOUT2_MS = 20;
	localparam logic [15:0] EX_TIMEOUT1_TICKS =
		16'(EX_TIMEOUT1_MS * 1000000 / TICK_NS);
	localparam logic [15:0] EX_TIMEOUT2_TICKS =
		16'(EX_TIMEOUT2_MS * 1000000 / TICK_NS);
	// ------------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_JUMP = 12'h004;
	localparam logic [11:0] OFS_SW_DATA = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00C;
	localparam logic [11:0] OFS_DRV_CFG0 = 12'h010;
	localparam logic [1:0] TABLE_REGION = 2'h2;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_EXAMPLE_BIT = 1;
	// ------------------------------------------------------------------
	// Cell word fields
	// ------------------------------------------------------------------
	localparam int W_OUT = 0;
	localparam int W_SEQ = 1;
	localparam int W_TMO = 2;
	localparam int W_MON = 3;
	localparam int EX_SEL_LSB = 0;
	localparam int EX_LVL_BIT = 4;
	localparam int EX_NEXT_LSB = 5;
	localparam int EX_EN_BIT = 11;
	localparam int EX_DLY_LSB = 16;
	localparam int MON_EXP_LSB = 11;
	localparam int MON_NEXT_LSB = 22;
	localparam int MON_EN_BIT = 28;
	localparam logic [3:0] SEL_WARNING = 4'hA;
	// ------------------------------------------------------------------
	// Driver output configuration
	// ------------------------------------------------------------------
	localparam logic [1:0] SRC_ENGINE = 2'h0;
	localparam logic [1:0] SRC_SOFTWARE = 2'h1;
	localparam logic [1:0] SRC_CLOCK = 2'h2;
	localparam int CFG_SRC_LSB = 0;
	localparam int CFG_MODE_LSB = 2;
	localparam logic [2:0] MODE_PASSIVE_LOW = 3'h0;
	localparam logic [2:0] MODE_OPEN_DRAIN = 3'h1;
	localparam logic [2:0] MODE_WEAK_VDD = 3'h2;
	localparam logic [2:0] MODE_STRONG_VDD = 3'h3;
	localparam logic [2:0] MODE_WEAK_VP = 3'h4;
	localparam logic [2:0] MODE_STRONG_VP = 3'h5;
	localparam logic [2:0] MODE_STRONG_PD = 3'h6;
	localparam logic [2:0] MODE_CHARGE_PUMP = 3'h7;
	typedef enum logic [1:0] {ST_OFF, ST_LOAD, ST_RUN} eng_state_t;
endpackage : seq_pkg

// file: hw/delay_timer.sv
// Tick-based delay timer used by the sequence and timeout exits.
`timescale 1ns/1ps
`default_nettype none
module delay_timer (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic tick,
	input wire logic restart,
	input wire logic [15:0] limit,
	output logic done
);
	import seq_pkg::*;
	logic [15:0] count_r;
	logic [15:0] count_nxt;

	always_comb begin
		count_nxt = count_r;
		if (restart) begin
			count_nxt = 16'h0000;
		end else if (tick && (count_r < limit)) begin
			count_nxt = count_r + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_r <= 16'h0000;
		end else if (ce) begin
			count_r <= count_nxt;
		end
	end

	// A zero limit is done at once; restart always wins over elapsed time.
	assign done = !restart && (count_r >= limit);
endmodule : delay_timer
`default_nettype wire

// file: hw/driver_output_mux.sv
// One programmable driver output: data source and drive mode selection.
`timescale 1ns/1ps
`default_nettype none
module driver_output_mux #(
	parameter bit PUMP_OK = 1'b0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic latched,
	input wire logic engine_level,
	input wire logic software_level,
	input wire logic clock_level,
	input wire logic [4:0] cfg,
	output logic level,
	output logic [2:0] mode
);
	import seq_pkg::*;
	logic level_r;
	logic level_nxt;
	logic [2:0] mode_r;
	logic [2:0] mode_nxt;
	logic [1:0] src;

	assign src = cfg[CFG_SRC_LSB +: 2];

	always_comb begin
		mode_nxt = cfg[CFG_MODE_LSB +: 3];
		if (!PUMP_OK && mode_nxt == MODE_CHARGE_PUMP) begin
			mode_nxt = MODE_OPEN_DRAIN; // [R13]
		end
		case (src) // [R11]
			SRC_ENGINE: level_nxt = engine_level;
			SRC_SOFTWARE: level_nxt = software_level;
			SRC_CLOCK: level_nxt = clock_level; // [R12]
			default: level_nxt = 1'b0;
		endcase
		if (!latched) begin
			mode_nxt = MODE_PASSIVE_LOW; // [R14] [R15]
			level_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			level_r <= 1'b0;
			mode_r <= MODE_PASSIVE_LOW;
		end else if (ce) begin
			level_r <= level_nxt;
			mode_r <= mode_nxt;
		end
	end

	assign level = level_r;
	assign mode = mode_r;
endmodule : driver_output_mux
`default_nettype wire

// file: hw/supply_sequencing_state_engine.sv
// Supply sequencing state engine with APB configuration and state table.
//
// How it works
// R1 - Table holds 63 cells, each giving outputs, exits and targets.
// R2 - Each state watches ten detector status inputs.
// R3 - Status inputs come already filtered from the fault detectors.
// R4 - Every exit target is a free six-bit index into the table.
// R5 - Sequence, monitor and timeout exits each carry their own target.
// R6 - Sequence and timeout delays are separate, reload on entry, to 400 ms.
// R7 - Driver levels are latched on entry and held for the whole state.
// R8 - Entering a state loads its cell in one cycle, far under 20 us.
// R9 - All warnings are ORed into one input usable by every exit.
// R10 - A software jump forces the sequence exit of the current state.
// R11 - Each output picks engine, software bit or clock as its source.
// R12 - A 100 kHz clock is made internally and routable to outputs.
// R13 - Drive mode is per output; charge pump only on outputs one to six.
// R14 - All configuration resets to zero; outputs then stay pulled low.
// R15 - Outputs follow configuration only after supply ok and enable latch.
// R16 - Example: rail one enable state exits to disable if input two bad.
// R17 - Example: power good exits to fault select one on inputs one to three.
// R18 - A sequence delay restarts whenever the watched condition changes.
// R19 - The monitor exit has no delay and ORs masked deviations.
// R20 - Priority on a tie: monitor, then timeout, then sequence.
`timescale 1ns/1ps
`default_nettype none
module supply_sequencing_state_engine #(
	parameter int TICK_LEN = seq_pkg::TICK_CYCLES
) (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic CLK_EN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [seq_pkg::NUM_IN-1:0] DETECTOR_STATUS,
	input wire logic [seq_pkg::NUM_IN-1:0] ADC_LIMIT_WARN,
	input wire logic [4:0] SECONDARY_WARN,
	input wire logic SUPPLY_OK,
	output logic [seq_pkg::NUM_OUT-1:0] DRIVER_OUTPUT,
	output logic [3*seq_pkg::NUM_OUT-1:0] DRIVER_MODE
);
	import seq_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [1:0] ctrl_r;
	logic [1:0] ctrl_nxt;
	logic jump_r;
	logic jump_nxt;
	logic [NUM_OUT-1:0] sw_r;
	logic [NUM_OUT-1:0] sw_nxt;
	logic [4:0] cfg_r [NUM_OUT];
	logic [4:0] cfg_nxt [NUM_OUT];
	logic [31:0] table_mem [TABLE_WORDS];
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic setup;
	logic wr_access;
	logic in_table;
	logic [7:0] tbl_idx;
	logic cfg_hit;
	logic [3:0] cfg_idx;
	logic jump_wr;
	logic [8:0] tick_cnt_r;
	logic [8:0] tick_cnt_nxt;
	logic tick;
	logic [7:0] clk_cnt_r;
	logic [7:0] clk_cnt_nxt;
	logic clkout_r;
	logic clkout_nxt;
	eng_state_t st_r;
	eng_state_t st_nxt;
	logic [5:0] cur_r;
	logic [5:0] cur_nxt;
	logic [31:0] cell_r [WORDS_PER_CELL];
	logic [31:0] cell_nxt [WORDS_PER_CELL];
	logic [NUM_OUT-1:0] se_out_r;
	logic [NUM_OUT-1:0] se_out_nxt;
	logic seq_prev_r;
	logic seq_prev_nxt;
	logic warning;
	logic [NUM_IN:0] in_vec;
	logic seq_cond;
	logic tmo_cond;
	logic seq_done;
	logic tmo_done;
	logic seq_hit;
	logic tmo_hit;
	logic mon_hit;
	logic running;
	logic latched;
	logic consume;

	// ------------------------------------------------------------------
	// Built-in example program
	// ------------------------------------------------------------------
	function automatic logic [31:0] exit_w(input logic [3:0] sel,
			input logic lvl, input logic [5:0] nxt, input logic [15:0] dly);
		exit_w = {dly, 4'h0, 1'b1, nxt, lvl, sel};
	endfunction : exit_w

	function automatic logic [31:0] mon_w(input logic [10:0] mask,
			input logic [5:0] nxt);
		mon_w = {3'h0, 1'b1, nxt, mask, mask};
	endfunction : mon_w

	// Cells: 0 idle one, 1 idle two, 2 first rail enable, 3 second rail
	// enable, 4 first rail disable, 5 second rail disable, 6 power good,
	// 7 fault select one, 8 fault select two. Inputs: 0..3 supply inputs,
	// 4 high voltage input, 5..9 auxiliary inputs.
	function automatic logic [31:0] example_word(input logic [5:0] c,
			input logic [1:0] w);
		logic [31:0] o;
		logic [31:0] s;
		logic [31:0] t;
		logic [31:0] m;
		o = 32'h0000_0000;
		s = 32'h0000_0000;
		t = 32'h0000_0000;
		m = 32'h0000_0000;
		case (c)
			6'd0: s = exit_w(4'h5, 1'b0, 6'd1, 16'h0000);
			6'd1: s = exit_w(4'h0, 1'b1, 6'd2, 16'h0000);
			6'd2: begin
				o = 32'h0000_0001;
				s = exit_w(4'h1, 1'b1, 6'd3, 16'h0000);
				t = exit_w(4'h1, 1'b0, 6'd4, EX_TIMEOUT1_TICKS); // [R16]
				m = mon_w(11'h001, 6'd0);
			end
			6'd3: begin
				o = 32'h0000_0003;
				s = exit_w(4'h2, 1'b1, 6'd6, 16'h0000);
				t = exit_w(4'h2, 1'b0, 6'd5, EX_TIMEOUT2_TICKS);
				m = mon_w(11'h003, 6'd8);
			end
			6'd4: begin
				o = 32'h0000_0006;
				s = exit_w(4'h5, 1'b1, 6'd0, 16'h0000);
			end
			6'd5: begin
				o = 32'h0000_0005;
				s = exit_w(4'h5, 1'b1, 6'd0, 16'h0000);
			end
			6'd6: begin
				o = 32'h0000_0003;
				s = exit_w(4'h5, 1'b1, 6'd5, 16'h0000);
				m = mon_w(11'h007, 6'd7); // [R17]
			end
			6'd7: begin
				o = 32'h0000_0007;
				s = exit_w(4'h2, 1'b0, 6'd5, 16'h0000);
				m = mon_w(11'h003, 6'd8);
			end
			6'd8: begin
				o = 32'h0000_0007;
				s = exit_w(4'h1, 1'b0, 6'd4, 16'h0000);
				m = mon_w(11'h001, 6'd0);
			end
			default: o = 32'h0000_0000;
		endcase
		case (w)
			2'd0: example_word = o;
			2'd1: example_word = s;
			2'd2: example_word = t;
			default: example_word = m;
		endcase
	endfunction : example_word

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	assign setup = PSEL && !PENABLE;
	assign wr_access = CLK_EN && PSEL && PENABLE && PWRITE && !PSLVERR;
	assign in_table = (PADDR[11:10] == TABLE_REGION)
		&& (PADDR[9:4] != 6'(NUM_CELLS));
	assign tbl_idx = PADDR[9:2];
	assign cfg_idx = 4'((PADDR - OFS_DRV_CFG0) >> 2);
	assign cfg_hit = (PADDR >= OFS_DRV_CFG0)
		&& (PADDR < OFS_DRV_CFG0 + 12'(4 * NUM_OUT)) && (PADDR[1:0] == 2'h0);
	assign jump_wr = wr_access && (PADDR == OFS_JUMP) && PWDATA[0];

	always_comb begin
		ctrl_nxt = ctrl_r;
		sw_nxt = sw_r;
		for (int i = 0; i < NUM_OUT; i++) begin
			cfg_nxt[i] = cfg_r[i];
		end
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		if (wr_access) begin
			if (PADDR == OFS_CTRL) begin
				ctrl_nxt = PWDATA[1:0];
			end
			if (PADDR == OFS_SW_DATA) begin
				sw_nxt = PWDATA[NUM_OUT-1:0];
			end
			if (cfg_hit) begin
				cfg_nxt[cfg_idx] = PWDATA[4:0];
			end
		end
		if (setup) begin
			pslverr_nxt = 1'b0;
			prdata_nxt = 32'h0000_0000;
			if (PADDR == OFS_CTRL) begin
				prdata_nxt = {30'h0000_0000, ctrl_r};
			end else if (PADDR == OFS_JUMP) begin
				prdata_nxt = {31'h0000_0000, jump_r};
			end else if (PADDR == OFS_SW_DATA) begin
				prdata_nxt = {22'h00_0000, sw_r};
			end else if (PADDR == OFS_STATUS) begin
				prdata_nxt = {5'h00, warning, se_out_r, 8'h00,
					jump_r, running, cur_r};
			end else if (cfg_hit) begin
				prdata_nxt = {27'h000_0000, cfg_r[cfg_idx]};
			end else if (in_table) begin
				prdata_nxt = table_mem[tbl_idx];
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
	end

	// Software sets the jump request and the engine clears it whenever any exit is taken;
	// a request written in the clearing cycle survives.
	assign jump_nxt = jump_wr || (jump_r && !consume); // [R10]

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_r <= 2'h0; // [R14]
			jump_r <= 1'b0;
			sw_r <= '0;
			for (int i = 0; i < NUM_OUT; i++) begin
				cfg_r[i] <= 5'h00;
			end
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (CLK_EN) begin
			ctrl_r <= ctrl_nxt;
			jump_r <= jump_nxt;
			sw_r <= sw_nxt;
			for (int i = 0; i < NUM_OUT; i++) begin
				cfg_r[i] <= cfg_nxt[i];
			end
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// The state table is plain storage, written word by word.
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			for (int i = 0; i < TABLE_WORDS; i++) begin
				table_mem[i] <= 32'h0000_0000; // [R1] [R14]
			end
		end else if (CLK_EN && wr_access && in_table) begin
			table_mem[tbl_idx] <= PWDATA;
		end
	end

	assign PREADY = CLK_EN;
	assign PRDATA = prdata_r;
	assign PSLVERR = pslverr_r;

	// ------------------------------------------------------------------
	// Delay tick and 100 kHz clock
	// ------------------------------------------------------------------
	always_comb begin
		tick = (tick_cnt_r == 9'(TICK_LEN - 1));
		tick_cnt_nxt = tick ? 9'h000 : tick_cnt_r + 9'h001;
		clk_cnt_nxt = clk_cnt_r + 8'h01;
		clkout_nxt = clkout_r;
		if (clk_cnt_r == 8'(CLKOUT_HALF_CYCLES - 1)) begin
			clk_cnt_nxt = 8'h00;
			clkout_nxt = !clkout_r; // [R12]
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			tick_cnt_r <= 9'h000;
			clk_cnt_r <= 8'h00;
			clkout_r <= 1'b0;
		end else if (CLK_EN) begin
			tick_cnt_r <= tick_cnt_nxt;
			clk_cnt_r <= clk_cnt_nxt;
			clkout_r <= clkout_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Exit evaluation
	// ------------------------------------------------------------------
	assign warning = |ADC_LIMIT_WARN || |SECONDARY_WARN; // [R9]
	assign in_vec = {warning, DETECTOR_STATUS}; // [R2] [R3]
	assign running = (st_r == ST_RUN);
	assign latched = (st_r != ST_OFF);

	always_comb begin
		seq_cond = cell_r[W_SEQ][EX_EN_BIT]
			&& (cell_r[W_SEQ][EX_SEL_LSB +: 4] <= SEL_WARNING)
			&& (in_vec[cell_r[W_SEQ][EX_SEL_LSB +: 4]]
			== cell_r[W_SEQ][EX_LVL_BIT]);
		tmo_cond = cell_r[W_TMO][EX_EN_BIT]
			&& (cell_r[W_TMO][EX_SEL_LSB +: 4] <= SEL_WARNING)
			&& (in_vec[cell_r[W_TMO][EX_SEL_LSB +: 4]]
			== cell_r[W_TMO][EX_LVL_BIT]);
		mon_hit = cell_r[W_MON][MON_EN_BIT] && |(cell_r[W_MON][10:0]
			& (in_vec ^ cell_r[W_MON][MON_EXP_LSB +: 11])); // [R19]
		tmo_hit = tmo_cond && tmo_done;
		seq_hit = (seq_cond && seq_done) || jump_r; // [R10]
	end

	delay_timer seq_timer (
		.clk(CORE_CLK),
		.resetn(RESETN),
		.ce(CLK_EN),
		.tick(tick),
		.restart(!running || (seq_cond != seq_prev_r)), // [R6] [R18]
		.limit(cell_r[W_SEQ][EX_DLY_LSB +: 16]),
		.done(seq_done)
	);

	delay_timer tmo_timer (
		.clk(CORE_CLK),
		.resetn(RESETN),
		.ce(CLK_EN),
		.tick(tick),
		.restart(!running), // [R6]
		.limit(cell_r[W_TMO][EX_DLY_LSB +: 16]),
		.done(tmo_done)
	);

	// ------------------------------------------------------------------
	// Engine state machine
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		cur_nxt = cur_r;
		se_out_nxt = se_out_r;
		seq_prev_nxt = seq_cond;
		consume = 1'b0;
		for (int w = 0; w < WORDS_PER_CELL; w++) begin
			cell_nxt[w] = cell_r[w];
		end
		case (st_r)
			ST_OFF: begin
				cur_nxt = 6'd0;
				se_out_nxt = '0;
				if (SUPPLY_OK && ctrl_r[CTRL_ENABLE_BIT]) begin
					st_nxt = ST_LOAD; // [R15]
				end
			end
			ST_LOAD: begin
				for (int w = 0; w < WORDS_PER_CELL; w++) begin
					if (ctrl_r[CTRL_EXAMPLE_BIT]) begin
						cell_nxt[w] = example_word(cur_r, 2'(w));
					end else if (cur_r == 6'(NUM_CELLS)) begin
						cell_nxt[w] = 32'h0000_0000;
					end else begin
						cell_nxt[w] = table_mem[{cur_r, 2'(w)}];
					end
				end
				se_out_nxt = cell_nxt[W_OUT][NUM_OUT-1:0]; // [R7] [R8]
				seq_prev_nxt = 1'b0;
				st_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (mon_hit) begin // [R20]
					cur_nxt = cell_r[W_MON][MON_NEXT_LSB +: 6]; // [R4] [R5]
					st_nxt = ST_LOAD;
				end else if (tmo_hit) begin
					cur_nxt = cell_r[W_TMO][EX_NEXT_LSB +: 6];
					st_nxt = ST_LOAD;
				end else if (seq_hit) begin
					cur_nxt = cell_r[W_SEQ][EX_NEXT_LSB +: 6];
					st_nxt = ST_LOAD;
				end
				consume = (st_nxt == ST_LOAD);
			end
			default: st_nxt = ST_OFF;
		endcase
		if (!SUPPLY_OK || !ctrl_r[CTRL_ENABLE_BIT]) begin
			st_nxt = ST_OFF;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			st_r <= ST_OFF;
			cur_r <= 6'd0;
			se_out_r <= '0;
			seq_prev_r <= 1'b0;
			for (int w = 0; w < WORDS_PER_CELL; w++) begin
				cell_r[w] <= 32'h0000_0000;
			end
		end else if (CLK_EN) begin
			st_r <= st_nxt;
			cur_r <= cur_nxt;
			se_out_r <= se_out_nxt;
			seq_prev_r <= seq_prev_nxt;
			for (int w = 0; w < WORDS_PER_CELL; w++) begin
				cell_r[w] <= cell_nxt[w];
			end
		end
	end

	// ------------------------------------------------------------------
	// Driver outputs
	// ------------------------------------------------------------------
	for (genvar i = 0; i < NUM_OUT; i++) begin : g_drv
		driver_output_mux #(
			.PUMP_OK(i < PUMP_OUTPUTS) // [R13]
		) u_drv (
			.clk(CORE_CLK),
			.resetn(RESETN),
			.ce(CLK_EN),
			.latched(latched), // [R15]
			.engine_level(se_out_r[i]),
			.software_level(sw_r[i]),
			.clock_level(clkout_r),
			.cfg(cfg_r[i]), // [R11]
			.level(DRIVER_OUTPUT[i]),
			.mode(DRIVER_MODE[3*i +: 3])
		);
	end
endmodule : supply_sequencing_state_engine
`default_nettype wire

// file: sim/supply_sequencing_state_engine_assertions.sv
// Port-level checker for the supply sequencing state engine.
`timescale 1ns/1ps
`default_nettype none
module seq_engine_checker (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [9:0] ADC_LIMIT_WARN,
	input wire logic [4:0] SECONDARY_WARN,
	input wire logic SUPPLY_OK,
	input wire logic [9:0] DRIVER_OUTPUT,
	input wire logic [29:0] DRIVER_MODE
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	wire logic acc = PSEL && PENABLE && PREADY;
	wire logic warn = |{ADC_LIMIT_WARN, SECONDARY_WARN};
	wire logic bad = PADDR >= 12'hBF0 || (PADDR >= 12'h038 && PADDR < 12'h800);
	property p_reset_low;
		$rose(RESETN) |-> DRIVER_OUTPUT == '0 && DRIVER_MODE == '0;
	endproperty
	a_reset_low: assert property (p_reset_low)
		else $error("outputs not low after reset");
	property p_supply_off;
		!SUPPLY_OK [*3] |-> DRIVER_OUTPUT == '0 && DRIVER_MODE == '0;
	endproperty
	a_supply_off: assert property (p_supply_off)
		else $error("outputs driven without supply");
	property p_no_pump;
		DRIVER_MODE[20:18] != 3'h7 && DRIVER_MODE[23:21] != 3'h7 &&
			DRIVER_MODE[26:24] != 3'h7 && DRIVER_MODE[29:27] != 3'h7;
	endproperty
	a_no_pump: assert property (p_no_pump)
		else $error("charge pump on output seven to ten");
	property p_hold;
		$changed(DRIVER_OUTPUT[2:0]) |=> $stable(DRIVER_OUTPUT[2:0]);
	endproperty
	a_hold: assert property (p_hold)
		else $error("engine outputs changed twice in a row");
	property p_unmapped;
		acc && bad |-> PSLVERR && (PWRITE || PRDATA == '0);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");
	property p_table_ok;
		acc && PADDR >= 12'h800 && PADDR < 12'hBF0 |-> !PSLVERR;
	endproperty
	a_table_ok: assert property (p_table_ok)
		else $error("table access refused");
	property p_regs_ok;
		acc && PADDR < 12'h038 && PADDR[1:0] == 2'h0 |-> !PSLVERR;
	endproperty
	a_regs_ok: assert property (p_regs_ok)
		else $error("register access refused");
	property p_warning;
		acc && !PWRITE && PADDR == 12'h00C && $past(warn, 3) == warn &&
			$past(warn, 2) == warn && $past(warn) == warn |-> PRDATA[26] == warn;
	endproperty
	a_warning: assert property (p_warning)
		else $error("warning bit differs from ORed warnings");
	c_run: cover property (DRIVER_OUTPUT[2:0] == 3'h3);
	c_disable: cover property (DRIVER_OUTPUT[2:0] == 3'h6);
	c_error: cover property (acc && PSLVERR);
endmodule : seq_engine_checker
bind supply_sequencing_state_engine seq_engine_checker u_seq_engine_checker (
	.CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .ADC_LIMIT_WARN(ADC_LIMIT_WARN),
	.SECONDARY_WARN(SECONDARY_WARN), .SUPPLY_OK(SUPPLY_OK),
	.DRIVER_OUTPUT(DRIVER_OUTPUT), .DRIVER_MODE(DRIVER_MODE));
`default_nettype wire

// file: sim/rail_model.sv
// Behavioural model of the two supply rails switched by the driver outputs.
`timescale 1ns/1ps
`default_nettype none
module rail_model #(
	parameter int RAMP = 20
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [1:0] en,
	input wire logic [1:0] fail,
	output logic [1:0] good
);
	int cnt_r [2];
	// A rail reports good only once its enable has held for the ramp time;
	// a failed rail drops at once and stays down until its fail clears, then ramps again. Status is a clean level.
	always @(posedge clk or negedge resetn) begin
		for (int i = 0; i < 2; i++) begin
			if (!resetn || !en[i] || fail[i]) begin
				cnt_r[i] <= 0;
				good[i] <= 1'b0;
			end else if (cnt_r[i] < RAMP) begin
				cnt_r[i] <= cnt_r[i] + 1;
			end else begin
				good[i] <= 1'b1;
			end
		end
	end
endmodule : rail_model
`default_nettype wire

// file: sim/test_supply_sequencing_state_engine.sv
// Self-checking bench for the supply sequencing state engine.
`timescale 1ns/1ps
`default_nettype none
module test_supply_sequencing_state_engine;
	import seq_pkg::*;
	logic clk = 0, rstn = 0, sok = 0, psel = 0, pen = 0, pwr = 0;
	logic vp1 = 1, vx1 = 0, slverr, rdy, tv;
	logic [11:0] pa = '0;
	logic [31:0] pwd = '0, rd, seed = 32'h3412;
	logic [9:0] adc = '0, dout;
	logic [5:0] misc = '0;
	logic [4:0] sec = '0;
	logic [1:0] fail = '0, good;
	logic [29:0] dmode;
	logic [32:0] q [$];
	int mismatches = 0, n_tests = 0, n;
	wire logic [9:0] det = {misc[5:2], vx1, misc[1:0], good, vp1};
	supply_sequencing_state_engine #(.TICK_LEN(4))
	u_supply_sequencing_state_engine (
		.CORE_CLK(clk), .RESETN(rstn), .CLK_EN(1'b1), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(rd),
		.PREADY(rdy), .PSLVERR(slverr), .DETECTOR_STATUS(det),
		.ADC_LIMIT_WARN(adc), .SECONDARY_WARN(sec), .SUPPLY_OK(sok),
		.DRIVER_OUTPUT(dout), .DRIVER_MODE(dmode));
	rail_model u_rail_model (.clk(clk), .resetn(rstn), .en(dout[1:0]),
		.fail(fail), .good(good));
	initial forever #12.5 clk = ~clk;
	// ------------------------------------------------------------------
	// Bus, compare and closing tasks
	// ------------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// A read notes its expected {error, data} for the watcher below.
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d, input logic [32:0] e = '0);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		if (!w) q.push_back(e);
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	always @(posedge clk)
		if (psel && pen && rdy === 1'b1 && !pwr)
			check({slverr, rd}, q.pop_front());
	task automatic wait_out(input logic [2:0] v);
		n = 0;
		while (dout[2:0] !== v && n < 8000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 8000) begin
			mismatches++;
			end_of_test();
		end
	endtask : wait_out
	task automatic status(input logic [31:0] e);
		repeat (40) @(posedge clk);
		apb(1'b0, OFS_STATUS, 32'h0, {1'b0, e});
	endtask : status
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	initial begin
		#1000000;
		mismatches++;
		end_of_test();
	end
	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a <= 16; a += 4) apb(1'b0, a[11:0], 32'h0);
		apb(1'b1, OFS_CTRL, 32'h3);
		status(32'h0);
		$display("reset values done");
		seed = lfsr(seed);
		misc <= seed[5:0];
		apb(1'b1, OFS_SW_DATA, {22'h0, seed[15:6] | 10'h008});
		apb(1'b0, OFS_SW_DATA, 32'h0, {23'h0, seed[15:6] | 10'h008});
		for (int i = 0; i < 3; i++) apb(1'b1, 12'(16 + 4 * i), 32'hC);
		apb(1'b1, 12'h01C, 32'hD);
		apb(1'b1, 12'h020, 32'hE);
		apb(1'b1, 12'h02C, 32'h1C);
		apb(1'b0, 12'hBF0, 32'h0, {1'b1, 32'h0});
		apb(1'b0, 12'h040, 32'h0, {1'b1, 32'h0});
		$display("register access done");
		sok <= 1'b1;
		wait_out(3'h3);
		status(32'h0003_0046);
		check(33'(dout[3]), 33'h1);
		check(33'({dmode[23:21], dmode[2:0]}),
			33'({MODE_OPEN_DRAIN, MODE_STRONG_VDD}));
		tv = dout[4];
		while (dout[4] === tv) @(posedge clk);
		n = 0;
		while (dout[4] !== tv && n < 1000) begin
			@(posedge clk);
			n++;
		end
		check(33'(n), 33'(CLKOUT_HALF_CYCLES));
		$display("power up done");
		fail <= 2'b10;
		wait_out(3'h5);
		status(32'h0005_0045);
		$display("fault path done");
		vx1 <= 1'b1;
		wait_out(3'h0);
		fail <= 2'b01;
		vx1 <= 1'b0;
		wait_out(3'h1);
		wait_out(3'h6);
		check(33'(n >= 3980 && n <= 4020), 33'h1);
		status(32'h0006_0044);
		$display("timeout done");
		vp1 <= 1'b0;
		apb(1'b1, OFS_JUMP, 32'h1);
		status(32'h0000_0041);
		$display("jump done");
		apb(1'b1, OFS_CTRL, 32'h0);
		adc <= seed[25:16] | 10'h1;
		status(32'h0400_0000);
		apb(1'b1, 12'hC00, 32'h1);
		check(33'(dmode), 33'h0);
		$display("warning done");
		adc <= '0;
		sec <= seed[4:0] | 5'h10;
		apb(1'b1, 12'h8F4, seed);
		apb(1'b0, 12'h8F4, 32'h0, {1'b0, seed});
		apb(1'b1, 12'h800, 32'h0000_0002);
		apb(1'b1, 12'h804, 32'h0032_083A);
		apb(1'b1, OFS_CTRL, 32'h1);
		wait_out(3'h2);
		status(32'h0402_0040);
		sec <= '0;
		@(posedge clk);
		sec <= seed[4:0] | 5'h10;
		wait_out(3'h0);
		check(33'(n >= 195 && n <= 215), 33'h1);
		$display("table program done");
		end_of_test();
	end
endmodule : test_supply_sequencing_state_engine
`default_nettype wire
